// ### rtl/aoc_defines.vh
// Purpose: Offsets, word width and timing counts for the angle path
//          configuration block.
// Assumes: 25 MHz system clock; registers are one aligned APB word each.
// Notes:   Register indices are kept as printed; byte address is index * 4.
`ifndef AOC_DEFINES_VH
`define AOC_DEFINES_VH
`define AOC_IDX_ANGLE_CALC   6'h32
`define AOC_IDX_GAIN         6'h33
`define AOC_IDX_POST_LIMIT   6'h34
`define AOC_IDX_MAG_LIMITS   6'h35
`define AOC_IDX_LOW_CLAMP    6'h36
`define AOC_IDX_FILT_UCLAMP  6'h37
`define AOC_IDX_STARTUP      6'h38
`define AOC_IDX_DIG_OUT      6'h39
`define AOC_IDX_SLOW_SEL     6'h3a
`define AOC_IDX_UNLOCK_FILT  6'h3b
`define AOC_IDX_THRESH       6'h16
`define AOC_IDX_STATUS       6'h3e
`define AOC_IDX_RESULT       6'h3f
`define AOC_REG_W            26
`define AOC_HALF_SCALE       17'h08000
`define AOC_POD_STEP_US      500
`define AOC_POD_LONG_US      4000
`define AOC_CLK_MHZ          25
`define AOC_POD_STEP_CYC     (`AOC_POD_STEP_US * `AOC_CLK_MHZ)
`define AOC_POD_LONG_CYC     (`AOC_POD_LONG_US * `AOC_CLK_MHZ)
`define AOC_FR_05MS_CYC      (500 * `AOC_CLK_MHZ)
`define AOC_TICKS_3N         9'd210
`define AOC_TICKS_4N         9'd228
`define AOC_TICKS_6N         9'd282
`endif

// ### rtl/aoc_fault_filter.v
// Purpose: Persistence filter: a flag trips once its condition has held
//          for the selected number of consecutive updates.
// Assumes: i_cond is sampled on each i_tick.
// Notes:   A depth of zero passes the condition straight through.
`timescale 1ns/10ps
module aoc_fault_filter (
    // Clock and reset.
    input  wire       i_clk,
    input  wire       i_rst,
    // Condition and depth.
    input  wire       i_tick,
    input  wire       i_cond,
    input  wire [4:0] i_depth,
    // Filtered flag.
    output reg        o_flag
);
    reg [4:0] run; // Consecutive updates with the condition present.

    // Count runs of the condition; any gap restarts the count.
    always @(posedge i_clk) begin
        if (i_rst) begin
            run    <= 5'h00;
            o_flag <= 1'b0;
        end else if (i_tick) begin
            if (!i_cond) begin
                run    <= 5'h00;
                o_flag <= 1'b0;
            end else begin
                if (run != 5'h1f)
                    run <= run + 5'h01;
                o_flag <= ({1'b0, run} + 6'h01 >= {1'b0, i_depth});
            end
        end
    end
endmodule

// ### rtl/aoc_sent_remap.v
// Purpose: Remaps SENT data words and substitutes not-valid or error codes.
// Assumes: n is the data width selected by i_nbits (12 or 16 here).
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module aoc_sent_remap (
    // Data in.
    input  wire [15:0] i_data,
    input  wire [4:0]  i_nbits,
    input  wire        i_enable,
    input  wire        i_err1,
    input  wire        i_err2,
    input  wire        i_not_valid,
    // Data out.
    output reg  [15:0] o_data
);
    reg [16:0] full; // 2^n at full precision.

    // Apply the mapping; error and not-valid codes take priority.
    always @* begin
        full = 17'h00001 << i_nbits;
        o_data = i_data;
        if (i_enable) begin
            if (i_not_valid)
                o_data = 16'h0000;
            else if (i_err1)
                o_data = full[15:0] - 16'h0005;
            else if (i_err2)
                o_data = full[15:0] - 16'h0006;
            else if (i_data == 16'h0000)
                o_data = 16'h0001;
            else if ({1'b0, i_data} >= full - 17'h00008)
                o_data = full[15:0] - 16'h0008;
        end
    end
endmodule

// ### rtl/aoc_top.v
// Purpose: Shadowed configuration words and the short-stroke angle path
//          with magnitude checks, fault filters, start-up delay and SENT
//          data selection, reached over APB.
// Assumes: Inputs synchronous to I_CLK_SYS; shadow loads from I_NV_* at
//          reset release.
// Notes:   Filter, serial and driver fields are held and exported only.
`timescale 1ns/10ps
`include "aoc_defines.vh"
module aoc_top #(
    parameter POD_STEP_CYC = `AOC_POD_STEP_CYC,
    parameter POD_LONG_CYC = `AOC_POD_LONG_CYC,
    parameter FR_BASE_CYC  = `AOC_FR_05MS_CYC
) (
    // Clock and reset.
    input  wire        I_CLK_SYS,
    input  wire        I_SYS_RST,
    // APB slave.
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [7:0]  I_PADDR,
    input  wire [31:0] I_PWDATA,
    output reg  [31:0] O_PRDATA,
    output reg         O_PREADY,
    output reg         O_PSLVERR,
    // Non-volatile image, ten words packed low index first, plus 0x16.
    input  wire [259:0] I_NV_WORDS,
    input  wire [25:0]  I_NV_THRESH,
    // Signal path inputs.
    input  wire        I_UPDATE,
    input  wire [15:0] I_CHAN_A,
    input  wire [15:0] I_CHAN_B,
    input  wire [15:0] I_ATAN_AB,
    input  wire [15:0] I_ATAN_BA,
    input  wire [7:0]  I_MAGNITUDE,
    input  wire        I_ACF_COND,
    input  wire        I_SAT_COR_COND,
    input  wire        I_SAT_LIN_COND,
    input  wire        I_SENT_ERR1,
    input  wire        I_SENT_ERR2,
    // Outputs.
    output reg  [15:0] O_ANGLE,
    output reg         O_ANGLE_VALID,
    output reg  [15:0] O_SENT_DATA,
    output reg         O_POR_HOLD,
    output reg  [6:0]  O_FLAGS,
    output reg  [1:0]  O_PROTOCOL,
    output reg  [4:0]  O_DATA_RATE,
    output reg  [2:0]  O_BW_CODE,
    output reg  [15:0] O_FRAME_CYC,
    output reg         O_CRC_WITH_STATUS,
    output reg         O_SLOW_CHANNEL_OFF
);
    // Shadow copies of the configuration words.
    reg [25:0] shadow [0:9];
    reg [25:0] thresh_word;                    // Protected word 0x16.
    reg        loaded;                         // Shadow load done.
    reg        valid_seen;                     // First update after delay.
    reg [23:0] pod_cnt;                        // Power-on delay counter.
    integer    k;
    // Convenient field views.
    wire [25:0] w_calc = shadow[0];
    wire [25:0] w_gain = shadow[1];
    wire [25:0] w_lim  = shadow[2];
    wire [25:0] w_mag  = shadow[3];
    wire [25:0] w_dig  = shadow[7];
    wire [25:0] w_flt  = shadow[9];
    wire [5:0]  idx    = I_PADDR[7:2];
    wire        in_map = (idx >= `AOC_IDX_ANGLE_CALC) &&
                         (idx <= `AOC_IDX_UNLOCK_FILT);
    wire [3:0]  sidx   = idx[3:0] - 4'h2;
    wire        apb_wr = I_PSEL && I_PENABLE && I_PWRITE;

    // Stage arithmetic; the pre-gain offset sum wraps at 16 bits, later stages keep their carry.
    reg  [16:0] src;       // Angle stage output.
    reg  [16:0] pre;       // After pre-gain offset.
    reg  [32:0] prod;      // After gain.
    reg  [32:0] post;      // After post-gain offset.
    reg  [15:0] limited;   // After rollover or saturation.
    reg  [15:0] clamped;   // After clamping.
    reg         sat_event; // Saturation or wrap taken.
    reg         clamp_hit; // Value fell outside the clamp.
    wire [16:0] roll_pt = {1'b0, w_lim[25:18], 8'hff};

    // Angle source, offset, gain, offset, limit, clamp, in order.
    always @* begin
        case ({w_calc[2], w_calc[1]})
            2'b00:   src = {1'b0, I_ATAN_AB};
            2'b01:   src = {1'b0, I_ATAN_BA};
            2'b10:   src = {1'b0, I_CHAN_A} + `AOC_HALF_SCALE;
            default: src = {1'b0, I_CHAN_B} + `AOC_HALF_SCALE;
        endcase
        if (w_calc[0])
            src = {1'b0, ~src[15:0]};
        // The 15-bit offset is sign extended into 16-bit angle space.
        pre = {1'b0, src[15:0] + {w_calc[17], w_calc[17:3]}};
        prod = {17'h00000, pre[15:0]} * {17'h00000, w_gain[15:0]};
        post = {17'h00000, prod[23:8]} + {17'h00000, w_lim[16:1]};
        sat_event = 1'b0;
        limited = post[15:0];
        if (w_lim[0] && (post > {16'h0000, roll_pt})) begin
            sat_event = 1'b1;
            if (!w_lim[17])
                limited = 16'h0000;
            else if (pre[15])
                limited = 16'h0000;
            else
                limited = roll_pt[15:0];
        end
        clamp_hit = 1'b0;
        clamped = limited;
        if (limited < shadow[4][15:0]) begin
            clamped = shadow[4][15:0];
            clamp_hit = 1'b1;
        end else if (limited > shadow[5][15:0]) begin
            clamped = shadow[5][15:0];
            clamp_hit = 1'b1;
        end
    end

    // Fault filter depths: two bits for the analog check, three otherwise.
    reg [4:0] acf_depth;
    reg [4:0] gen_depth;
    always @* begin
        acf_depth = (w_flt[16:15] == 2'b00) ? 5'h00 :
                    (5'h01 << w_flt[16:15]);
        case (w_flt[14:12])
            3'h1:    gen_depth = 5'h02;
            3'h2:    gen_depth = 5'h04;
            3'h3:    gen_depth = 5'h08;
            3'h4:    gen_depth = 5'h10;
            default: gen_depth = 5'h00;
        endcase
    end

    // Magnitude checks only count while their enable bit is set.
    wire mag_hi = w_mag[9] && (I_MAGNITUDE > w_mag[17:10]);
    wire mag_lo = w_mag[0] && (I_MAGNITUDE < w_mag[8:1]);
    wire [4:0] conds = {I_ACF_COND, mag_hi | mag_lo, clamp_hit,
                        sat_event | I_SAT_COR_COND, I_SAT_LIN_COND};
    wire [4:0] filt;

    // One persistence filter per fault source.
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_filt
            aoc_fault_filter u_filt (
                .i_clk   (I_CLK_SYS),
                .i_rst   (I_SYS_RST),
                .i_tick  (I_UPDATE),
                .i_cond  (conds[g]),
                .i_depth ((g == 4) ? acf_depth : gen_depth),
                .o_flag  (filt[g])
            );
        end
    endgenerate

    // Power-on delay in cycles; code 7 means no extra delay.
    reg [23:0] pod_target;
    always @* begin
        case (shadow[6][20:18])
            3'h6:    pod_target = POD_LONG_CYC[23:0];
            3'h7:    pod_target = 24'h000000;
            default: pod_target = POD_STEP_CYC[23:0] *
                                  ({21'h000000, shadow[6][20:18]} + 24'h1);
        endcase
    end

    // SENT data width: 12 bits normally, 16 for configuration code 0xf.
    wire [4:0] nbits = (w_dig[6:3] == 4'hf) ? 5'h10 : 5'h0c;
    wire       remap_cfg = (w_dig[6:3] == 4'h0) || (w_dig[6:3] == 4'h4) ||
                           (w_dig[6:3] == 4'h7) || (w_dig[6:3] == 4'hf);
    reg  [15:0] init_val;
    wire [16:0] full = 17'h00001 << nbits;
    always @* begin
        case (w_dig[21:19])
            3'h1:    init_val = full[15:0] - 16'h0007;
            3'h2:    init_val = full[15:0] - 16'h0004;
            3'h3:    init_val = full[15:0] - 16'h0003;
            3'h4:    init_val = full[15:0] - 16'h0002;
            3'h5:    init_val = full[15:0] - 16'h0001;
            default: init_val = 16'h0000;
        endcase
    end
    wire        in_init = (pod_target != 24'h000000) && !valid_seen;
    wire [15:0] sent_src = in_init ? init_val : clamped;
    wire [15:0] sent_mapped;
    aoc_sent_remap u_remap (
        .i_data      (sent_src),
        .i_nbits     (nbits),
        .i_enable    (w_dig[18] && remap_cfg && !in_init),
        .i_err1      (I_SENT_ERR1),
        .i_err2      (I_SENT_ERR2),
        .i_not_valid (!valid_seen && !in_init),
        .o_data      (sent_mapped)
    );

    // Shadow load at reset release, then APB writes to the shadow.
    always @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            loaded <= 1'b0;
            thresh_word <= 26'h0000000;
            for (k = 0; k < 10; k = k + 1)
                shadow[k] <= 26'h0000000;
        end else if (!loaded) begin
            loaded <= 1'b1;
            thresh_word <= I_NV_THRESH;
            for (k = 0; k < 10; k = k + 1)
                shadow[k] <= I_NV_WORDS[k*26 +: 26];
        end else if (apb_wr) begin
            if (in_map)
                shadow[sidx] <= I_PWDATA[25:0];
            else if ((idx == `AOC_IDX_THRESH) && w_flt[25])
                thresh_word <= I_PWDATA[25:0];
        end
    end

    // APB answers in the first access cycle; unmapped reads error.
    always @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= 32'h00000000;
        end else begin
            O_PREADY  <= I_PSEL && !I_PENABLE;
            O_PSLVERR <= I_PSEL && !I_PENABLE && !in_map &&
                         idx != `AOC_IDX_THRESH && idx != `AOC_IDX_STATUS &&
                         idx != `AOC_IDX_RESULT;
            if (in_map)
                O_PRDATA <= {6'h00, shadow[sidx]};
            else if (idx == `AOC_IDX_THRESH)
                O_PRDATA <= {6'h00, thresh_word};
            else if (idx == `AOC_IDX_STATUS)
                O_PRDATA <= {23'h000000, valid_seen, O_POR_HOLD, O_FLAGS};
            else if (idx == `AOC_IDX_RESULT)
                O_PRDATA <= {16'h0000, O_ANGLE};
            else
                O_PRDATA <= 32'h00000000;
        end
    end

    // Power-on hold, angle output and flag reporting.
    always @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            pod_cnt       <= 24'h000000;
            valid_seen    <= 1'b0;
            O_POR_HOLD    <= 1'b1;
            O_ANGLE       <= 16'h0000;
            O_ANGLE_VALID <= 1'b0;
            O_SENT_DATA   <= 16'h0000;
            O_FLAGS       <= 7'h00;
        end else begin
            if (loaded && O_POR_HOLD) begin
                if (pod_cnt >= pod_target)
                    O_POR_HOLD <= 1'b0;
                else
                    pod_cnt <= pod_cnt + 24'h000001;
            end
            O_ANGLE_VALID <= I_UPDATE && !O_POR_HOLD;
            if (I_UPDATE && !O_POR_HOLD) begin
                O_ANGLE    <= clamped;
                valid_seen <= 1'b1;
            end
            O_SENT_DATA <= sent_mapped;
            // Masks hide the report only; the data path is untouched.
            O_FLAGS <= {filt[4], filt[3] & w_mag[9], filt[3] & w_mag[0],
                        filt[2], filt[1] & ~w_flt[18],
                        filt[0] & ~w_flt[17], mag_hi & mag_lo};
        end
    end

    // Exported output-side settings and paused frame timing.
    always @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_PROTOCOL         <= 2'h0;
            O_DATA_RATE        <= 5'h00;
            O_BW_CODE          <= 3'h0;
            O_FRAME_CYC        <= 16'h0000;
            O_CRC_WITH_STATUS  <= 1'b0;
            O_SLOW_CHANNEL_OFF <= 1'b0;
        end else begin
            O_PROTOCOL  <= (w_dig[1:0] == 2'h3) ? 2'h0 : w_dig[1:0];
            O_DATA_RATE <= w_dig[11:7];
            O_BW_CODE   <= shadow[5][18:16];
            O_CRC_WITH_STATUS  <= w_dig[17];
            O_SLOW_CHANNEL_OFF <= w_dig[16];
            if (w_dig[23:22] == 2'h0)
                O_FRAME_CYC <= {7'h00, (nbits == 5'h10) ? `AOC_TICKS_6N :
                               (w_dig[6:3] == 4'h1) ? `AOC_TICKS_3N :
                               `AOC_TICKS_4N};
            else
                O_FRAME_CYC <= FR_BASE_CYC[15:0] <<
                               (w_dig[23:22] - 2'h1);
        end
    end
    // Adaptive bounds, settle count and loop gain stay in shadow[5],
    // shadow[6] and are read back over APB for the filter.
endmodule

// ### test/apo_path_chk.sv
// Purpose: Timing relations at the ports of the angle path block.
// Assumes: Bound to aoc_top; only its ports are seen.
// Notes:   Most values are judged by the testbench; this checks timing, refused-read data and the protocol code.
`timescale 1ns/10ps
module apo_path_chk (
    // Clock and reset.
    input logic        I_CLK_SYS,
    input logic        I_SYS_RST,
    // Requests.
    input logic        I_PSEL,
    input logic        I_PENABLE,
    input logic        I_PWRITE,
    input logic        I_UPDATE,
    // Answers.
    input logic [31:0] O_PRDATA,
    input logic        O_PREADY,
    input logic        O_PSLVERR,
    input logic        O_POR_HOLD,
    input logic        O_ANGLE_VALID,
    input logic [1:0]  O_PROTOCOL
);
    // One clock domain, so clock and reset are named once.
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);
    // Zero wait states: ready must land in the first access cycle.
    a_ready_in_access: assert property (
        I_PSEL && !I_PENABLE |=> O_PREADY && I_PENABLE)
        else $error("ready missing in first access cycle");
    a_ready_one_cycle: assert property (
        O_PREADY |=> !O_PREADY) else $error("ready held too long");
    a_ready_needs_access: assert property (
        O_PREADY |-> I_PSEL && I_PENABLE)
        else $error("ready outside an access");
    a_err_with_ready: assert property (
        O_PSLVERR |-> O_PREADY) else $error("error without ready");
    // A refused read must not leak stale data.
    a_err_read_zero: assert property (
        O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
        else $error("refused read returned data");
    // Codes 0 and 3 both mean PWM, so 3 never shows.
    a_proto_code: assert property (
        O_PROTOCOL != 2'h3) else $error("protocol code 3 seen");
    a_hold_no_angle: assert property (
        O_POR_HOLD |-> !O_ANGLE_VALID) else $error("data during hold");
    a_hold_never_back: assert property (
        !O_POR_HOLD |=> !O_POR_HOLD) else $error("hold rose again");
    a_valid_has_cause: assert property (
        O_ANGLE_VALID |-> $past(I_UPDATE))
        else $error("angle without update");
    a_update_gives_angle: assert property (
        I_UPDATE && !O_POR_HOLD |=> O_ANGLE_VALID)
        else $error("update lost");
endmodule
bind aoc_top apo_path_chk apo_path_chk_inst (.I_CLK_SYS, .I_SYS_RST,
    .I_PSEL, .I_PENABLE, .I_PWRITE, .I_UPDATE, .O_PRDATA, .O_PREADY,
    .O_PSLVERR, .O_POR_HOLD, .O_ANGLE_VALID, .O_PROTOCOL);

// ### test/apo_rx_model.sv
// Purpose: Receiving controller that takes one data word per update.
// Assumes: A word is offered on each angle valid pulse.
// Notes:   Pure sink; the link has no flow control to push back with.
`timescale 1ns/10ps
module apo_rx_model (
    // Clock and reset.
    input  logic        i_clk,
    input  logic        i_rst,
    // Offered word.
    input  logic        i_valid,
    input  logic [15:0] i_data,
    // Words taken and the latest one.
    output int          o_frames,
    output logic [15:0] o_last
);
    // Count every word and keep the latest.
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_frames <= 0;
            o_last   <= 16'h0000;
        end else if (i_valid) begin
            o_frames <= o_frames + 1;
            o_last   <= i_data;
        end
    end
endmodule

// ### test/angle_path_output_config_tb.sv
// Purpose: Self-checking bench for the angle path configuration block.
// Assumes: Shortened start-up and frame counts via parameters.
// Notes:   Expectations come from the field layouts, not the design.
`timescale 1ns/10ps
`include "aoc_defines.vh"
module angle_path_output_config_tb;
    localparam int STEP = 10;  // Start-up step, kept short.
    localparam int LONG = 80;
    localparam int FRB  = 50;
    logic         I_CLK_SYS, I_SYS_RST, I_PSEL, I_PENABLE, I_PWRITE;
    logic         I_UPDATE, I_ACF_COND, I_SAT_COR_COND, I_SAT_LIN_COND;
    logic         I_SENT_ERR1, I_SENT_ERR2, O_PREADY, O_PSLVERR;
    logic         O_ANGLE_VALID, O_POR_HOLD, O_CRC_WITH_STATUS;
    logic         O_SLOW_CHANNEL_OFF;
    logic [7:0]   I_PADDR, I_MAGNITUDE;
    logic [31:0]  I_PWDATA, O_PRDATA;
    logic [259:0] I_NV_WORDS;
    logic [25:0]  I_NV_THRESH;
    logic [15:0]  I_CHAN_A, I_CHAN_B, I_ATAN_AB, I_ATAN_BA;
    logic [15:0]  O_ANGLE, O_SENT_DATA, O_FRAME_CYC, init_data;
    logic [6:0]   O_FLAGS;
    logic [1:0]   O_PROTOCOL;
    logic [4:0]   O_DATA_RATE;
    logic [2:0]   O_BW_CODE;
    int           error_cnt = 0, n_checks = 0, n_upd = 0, frames;
    aoc_top #(.POD_STEP_CYC(STEP), .POD_LONG_CYC(LONG), .FR_BASE_CYC(FRB))
    aoc_top_inst (.I_CLK_SYS, .I_SYS_RST, .I_PSEL, .I_PENABLE, .I_PWRITE,
        .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_NV_WORDS,
        .I_NV_THRESH, .I_UPDATE, .I_CHAN_A, .I_CHAN_B, .I_ATAN_AB,
        .I_ATAN_BA, .I_MAGNITUDE, .I_ACF_COND, .I_SAT_COR_COND,
        .I_SAT_LIN_COND, .I_SENT_ERR1, .I_SENT_ERR2, .O_ANGLE,
        .O_ANGLE_VALID, .O_SENT_DATA, .O_POR_HOLD, .O_FLAGS, .O_PROTOCOL,
        .O_DATA_RATE, .O_BW_CODE, .O_FRAME_CYC, .O_CRC_WITH_STATUS,
        .O_SLOW_CHANNEL_OFF);
    apo_rx_model apo_rx_model_inst (.i_clk(I_CLK_SYS), .i_rst(I_SYS_RST),
        .i_valid(O_ANGLE_VALID), .i_data(O_SENT_DATA), .o_frames(frames),
        .o_last());
    // Free-running 25 MHz clock.
    initial begin
        I_CLK_SYS = 1'b0;
        forever #20 I_CLK_SYS = ~I_CLK_SYS;
    end
    // Value compare; case inequality so unknowns never match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single verdict point for normal end and watchdog alike.
    task report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One APB transfer; the request is held until ready is sampled.
    task automatic apb(input logic w, input logic [5:0] idx,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        @(posedge I_CLK_SYS);
        I_PSEL    <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE  <= w;
        I_PADDR   <= {idx, 2'b00};
        I_PWDATA  <= d;
        @(posedge I_CLK_SYS);
        I_PENABLE <= 1'b1;
        k = 0;
        @(posedge I_CLK_SYS);
        while (O_PREADY !== 1'b1 && k < 20) begin
            @(posedge I_CLK_SYS);
            k++;
        end
        if (k >= 20) error_cnt++;
        r = O_PRDATA;
        e = O_PSLVERR;
        I_PSEL    <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [31:0] x,
                       input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 32'h0, r, e);
        chk(r, x);
        chk(e, xe);
    endtask
    // One angle update; the answer stands for a single cycle.
    task automatic upd;
        int k;
        @(posedge I_CLK_SYS);
        I_UPDATE <= 1'b1;
        @(posedge I_CLK_SYS);
        I_UPDATE <= 1'b0;
        #1 k = 0;
        while (O_ANGLE_VALID !== 1'b1 && k < 4) begin
            @(posedge I_CLK_SYS);
            #1 k++;
        end
        chk(O_ANGLE_VALID, 1'b1);
        @(posedge I_CLK_SYS) #1 n_upd++;
    endtask
    // Reset with a start-up code and measure how long hold lasts.
    task automatic rst(input logic [2:0] code, input int exp);
        int n;
        @(posedge I_CLK_SYS);
        I_SYS_RST <= 1'b1;
        I_NV_WORDS[6*26+18 +: 3] <= code;
        repeat (20) @(posedge I_CLK_SYS);
        I_SYS_RST <= 1'b0;
        n = 0;
        @(posedge I_CLK_SYS);
        #1;
        while (O_POR_HOLD === 1'b1 && n < 200) begin
            if (n == 3)
                init_data = O_SENT_DATA;
            @(posedge I_CLK_SYS);
            #1 n++;
        end
        chk(n >= exp && n <= exp + 4, 1'b1);
    endtask
    task automatic t_shadow;
        for (int k = 0; k < 10; k++)
            rdc(6'h32 + k[5:0], I_NV_WORDS[k*26 +: 26], 1'b0);
    endtask
    // Threshold word is refused while locked; a hole answers error.
    task automatic t_lock;
        wr(`AOC_IDX_THRESH, 26'h1234);
        rdc(`AOC_IDX_THRESH, 32'h0abcd, 1'b0);
        wr(`AOC_IDX_UNLOCK_FILT, 26'h2000000);
        wr(`AOC_IDX_THRESH, 26'h1234);
        rdc(`AOC_IDX_THRESH, 32'h1234, 1'b0);
        wr(`AOC_IDX_UNLOCK_FILT, 26'h0);
        rdc(6'h00, 32'h0, 1'b1);
    endtask
    task automatic path(input logic [25:0] calc, gain, post,
                        input logic [31:0] clamp, input logic [15:0] x);
        wr(`AOC_IDX_ANGLE_CALC, calc);
        wr(`AOC_IDX_GAIN, gain);
        wr(`AOC_IDX_POST_LIMIT, post);
        wr(`AOC_IDX_LOW_CLAMP, clamp[15:0]);
        wr(`AOC_IDX_FILT_UCLAMP, clamp[31:16]);
        upd;
        chk(O_ANGLE, x);
    endtask
    // Sources, offsets, gain, limit and clamps, one row per case.
    task automatic t_path;
        path(26'h0, 26'h100, 26'h0, 32'hffff0000, 16'h0aaa);
        path(26'h2, 26'h100, 26'h0, 32'hffff0000, 16'h0bbb);
        path(26'h4, 26'h100, 26'h0, 32'hffff0000, 16'h9234);
        path(26'h6, 26'h100, 26'h0, 32'hffff0000, 16'hc321);
        path(26'h1, 26'h100, 26'h0, 32'hffff0000, 16'hf555);
        path(26'h80, 26'h200, 26'h200, 32'hffff0000, 16'h1674);
        path(26'h3ff80, 26'h100, 26'h0, 32'hffff0000, 16'h0a9a);
        path(26'h0, 26'h100, 26'h200000, 32'hffff0000, 16'h0aaa);
        path(26'h0, 26'h100, 26'h220001, 32'hffff0000, 16'h08ff);
        path(26'h0, 26'h100, 26'h0, 32'hffff2000, 16'h2000);
        path(26'h0, 26'h100, 26'h0, 32'h08000000, 16'h0800);
    endtask
    task automatic mag(input logic [25:0] w, input logic [7:0] m,
                       input logic [1:0] x);
        wr(`AOC_IDX_MAG_LIMITS, w);
        I_MAGNITUDE <= m;
        upd;
        chk(O_FLAGS[5:4], x);
    endtask
    task automatic t_mag;
        mag(26'h20241, 8'h90, 2'b11);
        mag(26'h20241, 8'h80, 2'b00);
        mag(26'h20241, 8'h20, 2'b00);
        mag(26'h20241, 8'h1f, 2'b11);
        mag(26'h20040, 8'h90, 2'b00);
        mag(26'h20040, 8'h10, 2'b00);
    endtask
    // Error codes and remap for 12- and 16-bit data.
    task automatic t_sent;
        wr(`AOC_IDX_DIG_OUT, 26'h40000);
        I_SENT_ERR1 <= 1'b1;
        upd;
        chk(O_SENT_DATA, 16'h0ffb);
        I_SENT_ERR1 <= 1'b0;
        I_SENT_ERR2 <= 1'b1;
        upd;
        chk(O_SENT_DATA, 16'h0ffa);
        wr(`AOC_IDX_DIG_OUT, 26'h40078);
        upd;
        chk(O_SENT_DATA, 16'hfffa);
        I_SENT_ERR2 <= 1'b0;
        wr(`AOC_IDX_FILT_UCLAMP, 26'h0);
        upd;
        chk(O_SENT_DATA, 16'h0001);
    endtask
    // Every protocol code, then frame periods and filter codes.
    task automatic t_out;
        for (int i = 0; i < 4; i++) begin
            wr(`AOC_IDX_DIG_OUT, i | 26'ha80 | (i[0] << 17) | (i[1] << 16));
            repeat (3) @(posedge I_CLK_SYS);
            chk({O_PROTOCOL, O_DATA_RATE, O_CRC_WITH_STATUS,
                 O_SLOW_CHANNEL_OFF}, {(i == 3) ? 2'd0 : i[1:0], 5'h15,
                 i[0], i[1]});
        end
        for (int f = 1; f < 4; f++) begin
            wr(`AOC_IDX_DIG_OUT, 2 | (f << 22));
            repeat (3) @(posedge I_CLK_SYS);
            chk(O_FRAME_CYC, FRB << (f - 1));
        end
        for (int b = 6; b < 8; b++) begin
            wr(`AOC_IDX_FILT_UCLAMP, 26'h0ffff | (b << 16));
            repeat (3) @(posedge I_CLK_SYS);
            chk(O_BW_CODE, b);
        end
    endtask
    // Condition held for n updates; the flag stays low before the n-th and reads trip on it.
    task automatic filt(input logic [25:0] w, input logic [2:0] c,
                        input int idx, n, input logic trip);
        wr(`AOC_IDX_UNLOCK_FILT, w);
        {I_ACF_COND, I_SAT_COR_COND, I_SAT_LIN_COND} <= 3'b000;
        upd;
        {I_ACF_COND, I_SAT_COR_COND, I_SAT_LIN_COND} <= c;
        repeat (n - 1) begin
            upd;
            chk(O_FLAGS[idx], 1'b0);
        end
        upd;
        chk(O_FLAGS[idx], trip);
    endtask
    task automatic t_filt;
        filt(26'h10000, 3'b100, 6, 4, 1'b1);
        filt(26'h18000, 3'b100, 6, 8, 1'b1);
        filt(26'h04000, 3'b010, 2, 16, 1'b1);
        filt(26'h05000, 3'b010, 2, 1, 1'b1);
        filt(26'h01000, 3'b001, 1, 2, 1'b1);
        filt(26'h41000, 3'b010, 2, 2, 1'b0);
    endtask
    // Watchdog: 40000 cycles, far beyond the expected several hundred.
    initial begin
        #(40 * 40000);
        error_cnt++;
        report_and_stop;
    end
    // Main sequence.
    initial begin
        {I_SYS_RST, I_PSEL, I_PENABLE, I_PWRITE, I_UPDATE} = 5'b10000;
        {I_ACF_COND, I_SAT_COR_COND, I_SAT_LIN_COND} = 3'b000;
        {I_SENT_ERR1, I_SENT_ERR2, I_PADDR, I_PWDATA} = '0;
        I_NV_WORDS = {26'h0, 26'h155, 26'h80000, 26'h0, 26'h0ffff,
                      26'h0, 26'h0, 26'h0, 26'h100, 26'h0};
        I_NV_THRESH = 26'h0abcd;
        {I_CHAN_A, I_CHAN_B} = {16'h1234, 16'h4321};
        {I_ATAN_AB, I_ATAN_BA} = {16'h0aaa, 16'h0bbb};
        I_MAGNITUDE = 8'h50;
        init_data = 16'h0;
        rst(3'd0, STEP);
        chk(init_data, 16'h0ff9);
        t_shadow;
        t_lock;
        t_path;
        t_mag;
        t_sent;
        t_out;
        t_filt;
        chk(frames, n_upd);
        rst(3'd6, LONG);
        rst(3'd7, 0);
        report_and_stop;
    end
endmodule
